// file: logic/cvt_consts.svh
// Offsets, field positions and reset values of the vertical timing block.
// Assumes nothing; included by the top module and the self-checking bench.
`ifndef CVT_CONSTS_SVH
`define CVT_CONSTS_SVH
`define CVT_PORT_IDX_MONO 16'h03B4
`define CVT_PORT_DAT_MONO 16'h03B5
`define CVT_PORT_IDX_COLOR 16'h03D4
`define CVT_PORT_DAT_COLOR 16'h03D5
`define CVT_IDX_OVERFLOW 8'h07
`define CVT_IDX_MAX_SCAN 8'h09
`define CVT_IDX_VDE_LOW 8'h12
`define CVT_IDX_ROW_OFS 8'h13
`define CVT_IDX_UNDERLINE 8'h14
`define CVT_IDX_VBS_LOW 8'h15
`define CVT_IDX_VBE 8'h16
`define CVT_IDX_MODE_CTL 8'h17
`define CVT_IDX_EXT_VDE 8'h31
`define CVT_IDX_EXT_VBS 8'h33
`define CVT_IDX_EXT_OFS 8'h41
`define CVT_REG_RESET 8'h00
`define CVT_OVF_VDE8 1
`define CVT_OVF_VDE9 6
`define CVT_OVF_VBS8 3
`define CVT_MSL_VBS9 5
`define CVT_UL_DWORD 6
`define CVT_UL_CNT4 5
`define CVT_MC_RESET 7
`define CVT_MC_BYTE 6
`define CVT_MC_WRAP 5
`define CVT_MC_CNT2 3
`endif

// file: logic/cvt_pkg.sv
// Types shared by the vertical timing block.
// Assumes nothing; uses none of the constants header.
package cvt_pkg;
  typedef enum logic [1:0] {
    CVT_ADDR_WORD = 2'b00,
    CVT_ADDR_BYTE = 2'b01,
    CVT_ADDR_DWORD = 2'b10
  } cvt_addr_mode_type;
  typedef enum logic {
    CVT_V_OPEN = 1'b0,
    CVT_V_BLANK = 1'b1
  } cvt_vstate_type;
endpackage

// file: logic/cvt_cfg_if.sv
// Decoded configuration carried from the register file to the two engines.
// Assumes the package is compiled first.
`timescale 1ns/10ps
interface cvt_cfg_if;
  import cvt_pkg::*;
  logic [11:0] vde;
  logic [11:0] vbs;
  logic [7:0] vbe;
  cvt_addr_mode_type addr_mode;
  logic cnt4;
  logic cnt2;
  logic no_wrap;
  logic [11:0] row_offset;
  logic offset_dword;
  modport src (output vde, vbs, vbe, addr_mode, cnt4, cnt2, no_wrap, row_offset,
    offset_dword);
  modport tim (input vde, vbs, vbe);
  modport adr (input addr_mode, cnt4, cnt2, no_wrap, row_offset, offset_dword);
endinterface

// file: logic/cvt_line_timer.sv
// Scan line counter with display enable and vertical blank generation.
// Assumes one horizontal retrace tick per scan line and a frame start pulse.
`timescale 1ns/10ps
module cvt_line_timer
  import cvt_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_hretrace_tick,
  input wire logic i_frame_start,
  cvt_cfg_if.tim cfg,
  output logic [11:0] o_line,
  output logic o_display_en,
  output logic o_vblank
);
  logic [11:0] line_ff;
  cvt_vstate_type vstate_ff;
  cvt_vstate_type nxt_vstate;
  logic [11:0] nxt_line;
  logic line_move;
  logic de_ff;

  assign line_move = i_frame_start | i_hretrace_tick;
  assign nxt_line = i_frame_start ? 12'h000 : line_ff + 12'h001;
  assign nxt_vstate = (nxt_line == cfg.vbs) ? CVT_V_BLANK :
    (nxt_line[7:0] == cfg.vbe) ? CVT_V_OPEN : vstate_ff;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      line_ff <= 12'h000;
      de_ff <= 1'b0;
      vstate_ff <= CVT_V_OPEN;
    end else if (line_move) begin
      line_ff <= nxt_line;
      de_ff <= (nxt_line <= cfg.vde);
      vstate_ff <= nxt_vstate;
    end
  end

  assign o_line = line_ff;
  assign o_display_en = de_ff;
  assign o_vblank = (vstate_ff == CVT_V_BLANK);

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  line_zero_a: assert property (i_frame_start |=> line_ff == 12'h000)
    else $error("Line counter not cleared at frame start.");
  de_last_a: assert property (line_move && nxt_line == cfg.vde + 12'h001 && cfg.vde != 12'hFFF
    |=> !de_ff)
    else $error("Display enable past last active line.");
  blank_start_a: assert property (line_move && nxt_line == cfg.vbs
    |=> o_vblank)
    else $error("Vertical blank did not start on its line.");
endmodule

// file: logic/cvt_addr_gen.sv
// Memory address counter with increment interval, row stepping and
// byte, word or doubleword reorganisation of the counter outputs.
// Assumes a character clock tick, a row end pulse and a frame start pulse.
`timescale 1ns/10ps
module cvt_addr_gen
  import cvt_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_char_tick,
  input wire logic i_row_end,
  input wire logic i_frame_start,
  cvt_cfg_if.adr cfg,
  output logic [15:0] o_fb_addr
);
  logic [1:0] div_ff;
  logic [1:0] div_last;
  logic step;
  logic [15:0] ma_ff;
  logic [15:0] base_ff;
  logic [15:0] row_step;
  logic [15:0] nxt_base;
  logic [15:0] reorg;
  logic [15:0] fb_ff;

  assign div_last = (cfg.cnt4 && !cfg.cnt2) ? 2'h3 : (cfg.cnt2 ? 2'h1 : 2'h0);
  assign step = i_char_tick && (div_ff == div_last);
  // Unit scaling lets one counter serve both word and doubleword pitches.
  assign row_step = cfg.offset_dword ? {3'h0, cfg.row_offset, 1'b0} :
    {4'h0, cfg.row_offset};
  assign nxt_base = base_ff + row_step;

  always_comb begin
    unique case (cfg.addr_mode)
      CVT_ADDR_BYTE: reorg = ma_ff;
      CVT_ADDR_DWORD: reorg = {ma_ff[13:0], ma_ff[13], ma_ff[12]};
      default: reorg = {ma_ff[14:0], cfg.no_wrap ? ma_ff[15] : ma_ff[13]};
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 2'h0;
      ma_ff <= 16'h0000;
      base_ff <= 16'h0000;
      fb_ff <= 16'h0000;
    end else begin
      fb_ff <= reorg;
      if (i_frame_start) begin
        div_ff <= 2'h0;
        ma_ff <= 16'h0000;
        base_ff <= 16'h0000;
      end else if (i_row_end) begin
        div_ff <= 2'h0;
        ma_ff <= nxt_base;
        base_ff <= nxt_base;
      end else if (i_char_tick) begin
        div_ff <= step ? 2'h0 : div_ff + 2'h1;
        if (step) begin
          ma_ff <= ma_ff + 16'h0001;
        end
      end
    end
  end

  assign o_fb_addr = fb_ff;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  step_every_a: assert property (i_char_tick && !cfg.cnt4 && !cfg.cnt2
    && !i_row_end && !i_frame_start |=> ma_ff == $past(ma_ff) + 16'h0001)
    else $error("Counter missed a character clock step.");
  word_shift_a: assert property (cfg.addr_mode == CVT_ADDR_WORD
    |=> fb_ff[15:1] == $past(ma_ff[14:0]))
    else $error("Word mode shift wrong.");
  dword_shift_a: assert property (cfg.addr_mode == CVT_ADDR_DWORD
    |=> fb_ff[15:2] == $past(ma_ff[13:0]))
    else $error("Doubleword mode shift wrong.");
  wrap_16k_a: assert property (cfg.addr_mode == CVT_ADDR_WORD && !cfg.no_wrap
    |=> fb_ff[0] == $past(ma_ff[13]))
    else $error("Word mode address not wrapped at 16KB.");
endmodule

// file: logic/cvt_top.sv
// Vertical timing, row offset, underline and address mode part of the CRT
// controller, with its indexed I/O register pair.
// Assumes ticks, sync and frame pulses come from the horizontal timing logic.
//
// Contract
// - Standard mode display end is 10 bits: low byte plus overflow bits 6, 1.
// - Extended mode display end is 12 bits, upper four from extension register.
// - Display end value is the number of the last active scan line.
// - Standard mode row offset is the 8-bit offset register.
// - Extended mode row offset is 12 bits, upper four from extension register.
// - Row offset counts words or doublewords per row, unit from clocking mode.
// - Doubleword bit set forces doubleword addressing whatever mode bit 6 says.
// - Shift counter outputs: word by one, byte none, doubleword by two.
// - Counter steps every 1, 2, 4 or 2 character clocks per count bits.
// - Underline drawn, in text mode only, on the character line given by the 5-bit field.
// - Standard blank start is 10 bits: max scan bit 5, overflow bit 3.
// - Extended blank start is 12 bits, upper four from extension register.
// - Blanking begins on the line equal to the blank start value.
// - Blanking ends where line low byte equals the 8-bit end value.
// - Reset bit clear holds both syncs inactive, nothing else changes.
// - Wrap bit clear wraps addresses at 16KB; set means no wrap.
// - The wrap setting acts only in word mode.
// - I/O control bit 0 selects standard or extended widths.
`include "cvt_consts.svh"
`timescale 1ns/10ps
module cvt_top
  import cvt_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  input wire logic i_color_base,
  input wire logic i_ext_mode_sel,
  input wire logic i_offset_dword,
  input wire logic i_text_mode,
  input wire logic i_char_tick,
  input wire logic i_hretrace_tick,
  input wire logic i_frame_start,
  input wire logic i_row_end,
  input wire logic [4:0] i_row_scan,
  input wire logic i_hsync_raw,
  input wire logic i_vsync_raw,
  output logic o_hsync,
  output logic o_vsync,
  output logic o_display_en,
  output logic o_vblank,
  output logic [11:0] o_scan_line,
  output logic [15:0] o_fb_addr,
  output logic [11:0] o_row_offset,
  output logic o_offset_dword,
  output logic o_underline_on
);
  logic [7:0] index_ff;
  logic [7:0] overflow_ff;
  logic [7:0] max_scan_ff;
  logic [7:0] vde_low_ff;
  logic [7:0] row_ofs_ff;
  logic [7:0] underline_ff;
  logic [7:0] vbs_low_ff;
  logic [7:0] vbe_ff;
  logic [7:0] mode_ctl_ff;
  logic [7:0] ext_vde_ff;
  logic [7:0] ext_vbs_ff;
  logic [7:0] ext_ofs_ff;
  logic [7:0] rdata_ff;
  logic hsync_ff;
  logic vsync_ff;
  logic underline_on_ff;
  logic [11:0] row_offset_ff;
  logic offset_dword_ff;

  wire hit_index;
  wire hit_data;
  wire wr_index;
  wire wr_data;
  wire [7:0] nxt_rdata;
  wire [7:0] data_rd;
  wire [11:0] vde_std;
  wire [11:0] vde_ext;
  wire [11:0] vbs_std;
  wire [11:0] vbs_ext;
  wire [11:0] ofs_std;
  wire [11:0] ofs_ext;
  wire [11:0] line;
  wire display_en;
  wire vblank;
  wire [15:0] fb_addr;
  wire sync_run;
  wire underline_hit;
  wire dword_sel;
  wire byte_sel;

  cvt_cfg_if cfg ();

  // The base select follows the mono or colour decode; the other pair is silent.
  assign hit_index = i_color_base ? (i_io_addr == `CVT_PORT_IDX_COLOR) :
    (i_io_addr == `CVT_PORT_IDX_MONO);
  assign hit_data = i_color_base ? (i_io_addr == `CVT_PORT_DAT_COLOR) :
    (i_io_addr == `CVT_PORT_DAT_MONO);
  assign wr_index = i_io_wr && hit_index;
  assign wr_data = i_io_wr && hit_data;

  assign data_rd = (index_ff == `CVT_IDX_OVERFLOW) ? overflow_ff :
    (index_ff == `CVT_IDX_MAX_SCAN) ? max_scan_ff :
    (index_ff == `CVT_IDX_VDE_LOW) ? vde_low_ff :
    (index_ff == `CVT_IDX_ROW_OFS) ? row_ofs_ff :
    (index_ff == `CVT_IDX_UNDERLINE) ? underline_ff :
    (index_ff == `CVT_IDX_VBS_LOW) ? vbs_low_ff :
    (index_ff == `CVT_IDX_VBE) ? vbe_ff :
    (index_ff == `CVT_IDX_MODE_CTL) ? mode_ctl_ff :
    (index_ff == `CVT_IDX_EXT_VDE) ? ext_vde_ff :
    (index_ff == `CVT_IDX_EXT_VBS) ? ext_vbs_ff :
    (index_ff == `CVT_IDX_EXT_OFS) ? ext_ofs_ff : 8'h00;
  assign nxt_rdata = hit_index ? index_ff : (hit_data ? data_rd : 8'h00);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      index_ff <= `CVT_REG_RESET;
      rdata_ff <= `CVT_REG_RESET;
    end else begin
      if (wr_index) begin
        index_ff <= i_io_wdata;
      end
      if (i_io_rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      overflow_ff <= `CVT_REG_RESET;
      max_scan_ff <= `CVT_REG_RESET;
      vde_low_ff <= `CVT_REG_RESET;
      row_ofs_ff <= `CVT_REG_RESET;
      underline_ff <= `CVT_REG_RESET;
      vbs_low_ff <= `CVT_REG_RESET;
      vbe_ff <= `CVT_REG_RESET;
      mode_ctl_ff <= `CVT_REG_RESET;
      ext_vde_ff <= `CVT_REG_RESET;
      ext_vbs_ff <= `CVT_REG_RESET;
      ext_ofs_ff <= `CVT_REG_RESET;
    end else if (wr_data) begin
      unique case (index_ff)
        `CVT_IDX_OVERFLOW: overflow_ff <= i_io_wdata;
        `CVT_IDX_MAX_SCAN: max_scan_ff <= i_io_wdata;
        `CVT_IDX_VDE_LOW: vde_low_ff <= i_io_wdata;
        `CVT_IDX_ROW_OFS: row_ofs_ff <= i_io_wdata;
        // Bit 7 is reserved and reads back as zero.
        `CVT_IDX_UNDERLINE: underline_ff <= {1'b0, i_io_wdata[6:0]};
        `CVT_IDX_VBS_LOW: vbs_low_ff <= i_io_wdata;
        `CVT_IDX_VBE: vbe_ff <= i_io_wdata;
        // Bit 4 is reserved and reads back as zero.
        `CVT_IDX_MODE_CTL: mode_ctl_ff <= {i_io_wdata[7:5], 1'b0, i_io_wdata[3:0]};
        `CVT_IDX_EXT_VDE: ext_vde_ff <= {4'h0, i_io_wdata[3:0]};
        `CVT_IDX_EXT_VBS: ext_vbs_ff <= {4'h0, i_io_wdata[3:0]};
        `CVT_IDX_EXT_OFS: ext_ofs_ff <= {4'h0, i_io_wdata[3:0]};
        default: ;
      endcase
    end
  end

  assign vde_std = {2'b00, overflow_ff[`CVT_OVF_VDE9], overflow_ff[`CVT_OVF_VDE8],
    vde_low_ff};
  assign vde_ext = {ext_vde_ff[3:0], vde_low_ff};
  assign vbs_std = {2'b00, max_scan_ff[`CVT_MSL_VBS9], overflow_ff[`CVT_OVF_VBS8],
    vbs_low_ff};
  assign vbs_ext = {ext_vbs_ff[3:0], vbs_low_ff};
  assign ofs_std = {4'h0, row_ofs_ff};
  assign ofs_ext = {ext_ofs_ff[3:0], row_ofs_ff};

  assign cfg.vde = i_ext_mode_sel ? vde_ext : vde_std;
  assign cfg.vbs = i_ext_mode_sel ? vbs_ext : vbs_std;
  assign cfg.row_offset = i_ext_mode_sel ? ofs_ext : ofs_std;
  assign cfg.vbe = vbe_ff;
  assign cfg.offset_dword = i_offset_dword;

  assign dword_sel = underline_ff[`CVT_UL_DWORD];
  assign byte_sel = mode_ctl_ff[`CVT_MC_BYTE];
  assign cfg.addr_mode = dword_sel ? CVT_ADDR_DWORD :
    (byte_sel ? CVT_ADDR_BYTE : CVT_ADDR_WORD);
  assign cfg.cnt4 = underline_ff[`CVT_UL_CNT4];
  assign cfg.cnt2 = mode_ctl_ff[`CVT_MC_CNT2];
  assign cfg.no_wrap = mode_ctl_ff[`CVT_MC_WRAP];

  cvt_line_timer u_line_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_hretrace_tick(i_hretrace_tick),
    .i_frame_start(i_frame_start),
    .cfg(cfg.tim),
    .o_line(line),
    .o_display_en(display_en),
    .o_vblank(vblank)
  );

  cvt_addr_gen u_addr_gen (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_char_tick(i_char_tick),
    .i_row_end(i_row_end),
    .i_frame_start(i_frame_start),
    .cfg(cfg.adr),
    .o_fb_addr(fb_addr)
  );

  // Only the syncs are gated, so counters keep running and resume in phase.
  assign sync_run = mode_ctl_ff[`CVT_MC_RESET];
  assign underline_hit = i_text_mode && (i_row_scan == underline_ff[4:0]);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hsync_ff <= 1'b0;
      vsync_ff <= 1'b0;
      underline_on_ff <= 1'b0;
      row_offset_ff <= 12'h000;
      offset_dword_ff <= 1'b0;
    end else begin
      hsync_ff <= sync_run && i_hsync_raw;
      vsync_ff <= sync_run && i_vsync_raw;
      underline_on_ff <= underline_hit;
      row_offset_ff <= cfg.row_offset;
      offset_dword_ff <= i_offset_dword;
    end
  end

  assign o_io_rdata = rdata_ff;
  assign o_hsync = hsync_ff;
  assign o_vsync = vsync_ff;
  assign o_display_en = display_en;
  assign o_vblank = vblank;
  assign o_scan_line = line;
  assign o_fb_addr = fb_addr;
  assign o_row_offset = row_offset_ff;
  assign o_offset_dword = offset_dword_ff;
  assign o_underline_on = underline_on_ff;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sync_held_off_a: assert property (!sync_run |=> !o_hsync && !o_vsync)
    else $error("Sync active while controller reset bit is clear.");
  vde_std_width_a: assert property (!i_ext_mode_sel
    |-> cfg.vde[11:10] == 2'b00 && cfg.vde[9] == overflow_ff[6])
    else $error("Standard display end formed wrongly.");
  vde_ext_width_a: assert property (i_ext_mode_sel
    |-> cfg.vde[11:8] == ext_vde_ff[3:0])
    else $error("Extended display end formed wrongly.");
  ofs_std_width_a: assert property (!i_ext_mode_sel
    |=> o_row_offset == {4'h0, $past(row_ofs_ff)})
    else $error("Standard row offset formed wrongly.");
  ofs_ext_width_a: assert property (i_ext_mode_sel
    |=> o_row_offset[11:8] == $past(ext_ofs_ff[3:0]))
    else $error("Extended row offset formed wrongly.");
  vbs_std_width_a: assert property (!i_ext_mode_sel
    |-> cfg.vbs[9] == max_scan_ff[5] && cfg.vbs[8] == overflow_ff[3])
    else $error("Standard blank start formed wrongly.");
  vbs_ext_width_a: assert property (i_ext_mode_sel
    |-> cfg.vbs[11:8] == ext_vbs_ff[3:0])
    else $error("Extended blank start formed wrongly.");
  underline_row_a: assert property (i_text_mode && i_row_scan == underline_ff[4:0]
    |=> o_underline_on)
    else $error("Underline missing on its character line.");
  index_write_a: assert property (wr_index |=> index_ff == $past(i_io_wdata))
    else $error("Index port write not captured.");
  vde_std_low_a: assert property (!i_ext_mode_sel
    |-> cfg.vde[8] == overflow_ff[`CVT_OVF_VDE8] && cfg.vde[7:0] == vde_low_ff)
    else $error("Standard display end low bits formed wrongly.");
  vde_ext_low_a: assert property (i_ext_mode_sel
    |-> cfg.vde[7:0] == vde_low_ff && cfg.vbs[7:0] == vbs_low_ff)
    else $error("Extended display end low byte formed wrongly.");
  vbs_std_low_a: assert property (!i_ext_mode_sel
    |-> cfg.vbs[11:10] == 2'b00 && cfg.vbs[7:0] == vbs_low_ff)
    else $error("Standard blank start low bits formed wrongly.");
  dword_force_a: assert property (underline_ff[`CVT_UL_DWORD]
    |-> cfg.addr_mode == CVT_ADDR_DWORD)
    else $error("Doubleword bit did not force doubleword addressing.");
  byte_mode_a: assert property (!underline_ff[`CVT_UL_DWORD] && mode_ctl_ff[`CVT_MC_BYTE]
    |-> cfg.addr_mode == CVT_ADDR_BYTE)
    else $error("Byte mode not selected.");
  word_mode_a: assert property (!underline_ff[`CVT_UL_DWORD] && !mode_ctl_ff[`CVT_MC_BYTE]
    |-> cfg.addr_mode == CVT_ADDR_WORD)
    else $error("Word mode not selected.");
  sync_follow_a: assert property (sync_run
    |=> o_hsync == $past(i_hsync_raw) && o_vsync == $past(i_vsync_raw))
    else $error("Sync not passed through during normal operation.");
  read_index_a: assert property (i_io_rd && hit_index
    |=> o_io_rdata == $past(index_ff))
    else $error("Index port read returned wrong value.");
  data_write_a: assert property (wr_data && index_ff == `CVT_IDX_VDE_LOW
    |=> vde_low_ff == $past(i_io_wdata))
    else $error("Data port write not captured.");
  underline_off_a: assert property (!i_text_mode
    |=> !o_underline_on)
    else $error("Underline shown outside text mode.");
  offset_unit_a: assert property (i_offset_dword
    |=> o_offset_dword)
    else $error("Row offset unit not passed on.");
endmodule

// file: tb/cvt_display_model.sv
// Display-side model that counts the sync pulses it receives.
// Assumes registered, active-high syncs from the controller on one clock.
`timescale 1ns/10ps
module cvt_display_model (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_hsync,
  input wire logic i_vsync,
  output logic [15:0] o_hsync_count,
  output logic [15:0] o_vsync_count
);
  logic hs_ff;
  logic vs_ff;
  // A monitor only reacts to edges, so a held sync level counts once.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hs_ff <= 1'b0;
      vs_ff <= 1'b0;
      o_hsync_count <= 16'h0000;
      o_vsync_count <= 16'h0000;
    end else begin
      hs_ff <= i_hsync;
      vs_ff <= i_vsync;
      o_hsync_count <= o_hsync_count + {15'h0000, i_hsync & !hs_ff};
      o_vsync_count <= o_vsync_count + {15'h0000, i_vsync & !vs_ff};
    end
  end
endmodule

// file: tb/cvt_top_bench.sv
// Self-checking bench of the vertical timing and address mode block.
// Assumes host reads answer one cycle after the read strobe.
`include "cvt_consts.svh"
`timescale 1ns/10ps
module cvt_top_bench;
  import cvt_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] i_io_addr = 16'h0000;
  logic [7:0] i_io_wdata = 8'h00;
  logic i_io_wr = 1'b0, i_io_rd = 1'b0, i_color_base = 1'b0, i_ext_mode_sel = 1'b0;
  logic i_offset_dword = 1'b0, i_text_mode = 1'b0, i_char_tick = 1'b0;
  logic i_hretrace_tick = 1'b0, i_frame_start = 1'b0, i_row_end = 1'b0;
  logic i_hsync_raw = 1'b0, i_vsync_raw = 1'b0;
  logic [4:0] i_row_scan = 5'h00;
  logic [7:0] o_io_rdata;
  logic o_hsync, o_vsync, o_display_en, o_vblank, o_offset_dword, o_underline_on;
  logic [11:0] o_scan_line, o_row_offset, vde, vbs;
  logic [15:0] o_fb_addr, hs_cnt, vs_cnt, eh, ev, ma, base, stp;
  logic [31:0] rnd = 32'h78D84C46;
  logic [7:0] rq[$];
  logic [7:0] regs [0:255];
  logic [7:0] idx_l [11] = '{8'h07, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
    8'h31, 8'h33, 8'h41};
  logic [7:0] msk_l [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hEF,
    8'h0F, 8'h0F, 8'h0F};
  logic [2:0] am_l [4] = '{3'b000, 3'b001, 3'b010, 3'b110};
  logic [2:0] am;
  logic vb, ph, pv, e1, e2;
  int bad_count = 0, n_tests = 0, div, ivl;

  cvt_top u_cvt_top (.*);
  cvt_display_model u_cvt_display_model (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_hsync(o_hsync),
    .i_vsync(o_vsync),
    .o_hsync_count(hs_cnt),
    .o_vsync_count(vs_cnt)
  );

  always #5 i_clk_sys = ~i_clk_sys;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [15:0] reorg(input logic [15:0] m, input logic [2:0] a);
    if (a[2]) return {m[13:0], m[13], m[12]};
    if (a[1]) return m;
    return {m[14:0], a[0] ? m[15] : m[13]};
  endfunction
  function automatic logic [15:0] pidx();
    return i_color_base ? `CVT_PORT_IDX_COLOR : `CVT_PORT_IDX_MONO;
  endfunction
  task automatic step();
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // An idle cycle follows every access so no strobe is driven twice at one time.
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    i_io_wr = wr;
    i_io_rd = !wr;
    i_io_addr = a;
    i_io_wdata = d;
    step();
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
    step();
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    io(1'b1, pidx(), idx);
    io(1'b1, pidx() + 16'h0001, d);
    regs[idx] = d;
  endtask
  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
    io(1'b1, pidx(), idx);
    rq.push_back(exp);
    io(1'b0, pidx() + 16'h0001, 8'h00);
  endtask
  task automatic fb_check();
    step();
    check("frame buffer address", o_fb_addr, reorg(ma, am));
  endtask
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    if (i_io_rd) begin
      #2;
      check("read data", {8'h00, o_io_rdata}, {8'h00, rq.pop_front()});
    end
  end

  initial begin
    #200000;
    bad_count++;
    test_done();
  end

  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'h00;
    repeat (4) step();
    i_rst = 1'b0;
    for (int b = 0; b < 2; b++) begin
      i_color_base = b[0];
      foreach (idx_l[j]) begin
        rnd = lfsr(rnd);
        wreg(idx_l[j], rnd[7:0]);
        rreg(idx_l[j], rnd[7:0] & msk_l[j]);
      end
      wreg(8'h20, 8'hFF);
      rreg(8'h20, 8'h00);
    end
    // A read at the mono data port is not decoded while colour base is chosen.
    rq.push_back(8'h00);
    io(1'b0, `CVT_PORT_DAT_MONO, 8'h00);
    // The index port reads back the index last written, here the unmapped one.
    rq.push_back(8'h20);
    io(1'b0, `CVT_PORT_IDX_COLOR, 8'h00);
    {eh, ev, ph, pv} = '0;
    for (int b = 0; b < 2; b++) begin
      // Raw syncs are parked low so enabling them cannot make an uncounted pulse.
      i_hsync_raw = 1'b0;
      i_vsync_raw = 1'b0;
      wreg(`CVT_IDX_MODE_CTL, {b[0], 7'h00});
      repeat (8) begin
        rnd = lfsr(rnd);
        i_hsync_raw = rnd[0];
        i_vsync_raw = rnd[1];
        e1 = rnd[0] & b[0];
        e2 = rnd[1] & b[0];
        eh = eh + {15'h0000, e1 & !ph};
        ev = ev + {15'h0000, e2 & !pv};
        {ph, pv} = {e1, e2};
        step();
        check("hsync", o_hsync, e1);
        check("vsync", o_vsync, e2);
      end
    end
    i_hsync_raw = 1'b0;
    i_vsync_raw = 1'b0;
    step();
    check("hsync pulses", hs_cnt, eh);
    check("vsync pulses", vs_cnt, ev);
    vb = 1'b0;
    for (int e = 0; e < 2; e++) begin
      i_ext_mode_sel = e[0];
      // Syncs stay off in the first pass to show that timing runs regardless.
      wreg(`CVT_IDX_MODE_CTL, {e[0], 7'h00});
      wreg(`CVT_IDX_OVERFLOW, 8'h02);
      wreg(`CVT_IDX_MAX_SCAN, 8'h20);
      wreg(`CVT_IDX_VDE_LOW, 8'h05);
      wreg(`CVT_IDX_VBS_LOW, 8'h10);
      wreg(`CVT_IDX_VBE, 8'h30);
      wreg(`CVT_IDX_EXT_VDE, 8'h03);
      wreg(`CVT_IDX_EXT_VBS, 8'h03);
      vde = e ? {regs[8'h31][3:0], regs[8'h12]} : {2'b00, regs[8'h07][6], regs[8'h07][1],
        regs[8'h12]};
      vbs = e ? {regs[8'h33][3:0], regs[8'h15]} : {2'b00, regs[8'h09][5], regs[8'h07][3],
        regs[8'h15]};
      i_frame_start = 1'b1;
      for (int l = 0; l < 832; l++) begin
        step();
        i_frame_start = 1'b0;
        i_hretrace_tick = 1'b0;
        if (l[11:0] == vbs) vb = 1'b1;
        else if (l[7:0] == regs[8'h16]) vb = 1'b0;
        check("scan line", o_scan_line, l[11:0]);
        check("display enable", o_display_en, l[11:0] <= vde);
        check("vblank", o_vblank, vb);
        step();
        i_hretrace_tick = 1'b1;
      end
      step();
      i_hretrace_tick = 1'b0;
    end
    wreg(`CVT_IDX_ROW_OFS, 8'h40);
    wreg(`CVT_IDX_EXT_OFS, 8'h0A);
    i_ext_mode_sel = 1'b0;
    step();
    check("row offset", o_row_offset, {4'h0, regs[8'h13]});
    i_ext_mode_sel = 1'b1;
    for (int k = 0; k < 16; k++) begin
      rnd = lfsr(rnd);
      am = am_l[k[3:2]];
      ivl = (k[1:0] == 2'b10) ? 4 : (k[1:0] == 2'b00) ? 1 : 2;
      wreg(`CVT_IDX_UNDERLINE, {1'b0, am[2], k[1], rnd[4:0]});
      wreg(`CVT_IDX_MODE_CTL, {1'b1, am[1], am[0], 1'b0, k[0], 3'b000});
      i_offset_dword = k[0] ^ k[2];
      i_text_mode = k[1];
      stp = {4'h0, regs[8'h41][3:0], regs[8'h13]} << i_offset_dword;
      i_frame_start = 1'b1;
      step();
      i_frame_start = 1'b0;
      {ma, base, div} = '0;
      fb_check();
      check("row offset", o_row_offset, {regs[8'h41][3:0], regs[8'h13]});
      check("offset unit", o_offset_dword, i_offset_dword);
      repeat (i_offset_dword ? 2 : 4) begin
        i_row_end = 1'b1;
        step();
        i_row_end = 1'b0;
        base = base + stp;
        ma = base;
        div = 0;
        fb_check();
      end
      repeat (5) begin
        i_char_tick = 1'b1;
        step();
        i_char_tick = 1'b0;
        div++;
        if (div == ivl) begin
          ma++;
          div = 0;
        end
        fb_check();
      end
      i_row_scan = rnd[4:0];
      step();
      check("underline", o_underline_on, i_text_mode);
      i_row_scan = rnd[4:0] + 5'h01;
      step();
      check("underline", o_underline_on, 16'h0000);
    end
    test_done();
  end
endmodule
